// ---- pcd_gate.sv ----
/*
  Peripheral clock disable: one gate cell per peripheral. It holds the
  enable state of one module and registers its clock enable, the write
  strobe into its registers and the read-valid flag.
  Assumes apply_i is a one-cycle pulse on mclk_i and that the peripheral
  and its register port run on mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module pcd_gate
  import pcd_pkg::*;
#(
  parameter logic PRESENT = 1'b1
)
(
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic apply_i,
  input  wire logic dis_i,
  input  wire logic on_i,
  input  wire logic wr_i,
  output pcd_gate_s gate_o
);

  logic en_reg;
  logic run_reg;
  logic wr_reg;
  logic rd_ok_reg;
  wire  logic en_next;

  // Absent module never enables, whatever the disable bit says
  assign en_next = apply_i ? (~dis_i & PRESENT) : en_reg;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      en_reg    <= PRESENT;
      run_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      rd_ok_reg <= PRESENT;
    end
    else
    begin
      en_reg    <= en_next;
      // Enable is a flop, so the gated clock can never see a runt pulse
      run_reg   <= en_next & on_i;
      wr_reg    <= en_reg & wr_i;
      rd_ok_reg <= en_next;
    end
  end

  assign gate_o.clk_en = run_reg;
  assign gate_o.wr_en  = wr_reg;
  assign gate_o.rd_ok  = rd_ok_reg;

endmodule

`default_nettype wire

// ---- pcd_top.sv ----
/*
  Peripheral clock disable: package of constants and the top module that
  holds the per-peripheral disable bits, times their effect by one
  instruction cycle and gates clocks and register access per peripheral.
  Assumes all control and peripheral signals are on mclk_i.
*/
package pcd_pkg;
  localparam int          PCD_NPERIPH   = 8;
  localparam logic [7:0]  PCD_PRESENT   = 8'hff;
  localparam int          PCD_CLK_NS    = 4;
  localparam int          PCD_ICYC_NS   = 8;
  localparam int          PCD_ICYC_CLKS =
    (PCD_ICYC_NS + PCD_CLK_NS - 1) / PCD_CLK_NS;
  localparam int          PCD_CNT_W     = 8;
  localparam logic [7:0]  PCD_WAIT_MAX  = 8'hff;

  typedef struct packed {
    logic clk_en;
    logic wr_en;
    logic rd_ok;
  } pcd_gate_s;
endpackage

`timescale 1ns/100ps
`default_nettype none

module pcd_top
  import pcd_pkg::*;
#(
  parameter int                 NPERIPH   = PCD_NPERIPH,
  parameter logic [NPERIPH-1:0] PRESENT   = PCD_PRESENT,
  parameter int                 ICYC_CLKS = PCD_ICYC_CLKS
)
(
  input  wire logic               mclk_i,
  input  wire logic               srst_i,
  input  wire logic               ctl_wr_i,
  input  wire logic [NPERIPH-1:0] ctl_wdata_i,
  input  wire logic [NPERIPH-1:0] periph_on_i,
  input  wire logic [NPERIPH-1:0] periph_wr_i,
  output logic      [NPERIPH-1:0] ctl_rdata_o,
  output logic                    pending_o,
  output pcd_gate_s [NPERIPH-1:0] gate_o
);

  // Counter is PCD_CNT_W bits wide, so the delay must fit in it
  if (NPERIPH < 1 || ICYC_CLKS < 1 || ICYC_CLKS > 255)
  begin : g_bad_param
    $error("pcd_top: unsupported NPERIPH or ICYC_CLKS");
  end

  localparam logic [PCD_CNT_W-1:0] CNT_LOAD =
    PCD_CNT_W'(ICYC_CLKS - 1);

  logic [NPERIPH-1:0]   dis_reg;
  logic [PCD_CNT_W-1:0] cnt_reg;
  logic                 pend_reg;
  wire  logic           apply_w;
  wire  logic [NPERIPH-1:0] clk_en_v;
  wire  logic [NPERIPH-1:0] wr_v;
  wire  logic [NPERIPH-1:0] rd_ok_v;

  // One instruction cycle elapses between the write and its effect
  assign apply_w = pend_reg & (cnt_reg == '0);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      dis_reg  <= '0;
      cnt_reg  <= '0;
      pend_reg <= 1'b0;
    end
    else if (ctl_wr_i)
    begin
      // Absent bits stay clear so software sees nothing there
      dis_reg  <= ctl_wdata_i & PRESENT;
      cnt_reg  <= CNT_LOAD;
      pend_reg <= 1'b1;
    end
    else if (pend_reg)
    begin
      if (cnt_reg == '0)
        pend_reg <= 1'b0;
      else
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign ctl_rdata_o = dis_reg;
  assign pending_o   = pend_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++)
    begin : g_gate
      pcd_gate #(
        .PRESENT (PRESENT[gi])
      ) u_gate (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .apply_i (apply_w),
        .dis_i   (dis_reg[gi]),
        .on_i    (periph_on_i[gi]),
        .wr_i    (periph_wr_i[gi]),
        .gate_o  (gate_o[gi])
      );
      assign clk_en_v[gi] = gate_o[gi].clk_en;
      assign wr_v[gi]     = gate_o[gi].wr_en;
      assign rd_ok_v[gi]  = gate_o[gi].rd_ok;
    end
  endgenerate

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  a_clock_when_off: assert property (
    (clk_en_v & ~rd_ok_v) == '0)
    else $error("clock runs to a disabled peripheral");

  a_write_blocked: assert property (
    !$past(srst_i) |-> wr_v == $past(periph_wr_i & rd_ok_v))
    else $error("register write passed to disabled peripheral");

  a_absent_off: assert property (
    ((rd_ok_v | clk_en_v | ctl_rdata_o) & ~PRESENT) == '0)
    else $error("absent peripheral shows as enabled");

  a_reset_enabled: assert property (
    $past(srst_i) |-> (rd_ok_v == PRESENT) && (ctl_rdata_o == '0))
    else $error("present peripheral not enabled after reset");

  sequence s_turned_off;
    !$past(srst_i) ##0 (($past(rd_ok_v) & ~rd_ok_v) != '0);
  endsequence

  sequence s_turned_on;
    !$past(srst_i) ##0 ((~$past(rd_ok_v) & rd_ok_v) != '0);
  endsequence

  // Timed from the write that carried the value: a newer write may
  // land on the very edge at which the older one takes effect
  a_disable_delay: assert property (
    s_turned_off |-> $past(ctl_wr_i, ICYC_CLKS + 1) &&
      rd_ok_v == (~$past(ctl_wdata_i, ICYC_CLKS + 1) & PRESENT))
    else $error("disable not one instruction cycle after write");

  a_enable_delay: assert property (
    s_turned_on |-> $past(ctl_wr_i, ICYC_CLKS + 1) &&
      rd_ok_v == (~$past(ctl_wdata_i, ICYC_CLKS + 1) & PRESENT))
    else $error("enable not one instruction cycle after write");

  a_clock_needs_on: assert property (
    !$past(srst_i) |-> (clk_en_v & ~$past(periph_on_i)) == '0)
    else $error("clock enabled while peripheral not switched on");

  a_gate_no_glitch: assert property (
    !$past(srst_i) && !$past(srst_i, 2) && $changed(clk_en_v)
    |-> $past(apply_w) || ($past(periph_on_i) != $past(periph_on_i, 2)))
    else $error("clock enable changed without a cause");

endmodule

`default_nettype wire

// ---- pcd_periph_model.sv ----
/*
  Model of the gated peripherals: each one toggles its run bit when a
  register write reaches it. Assumes gate_i is on mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module pcd_periph_model
  import pcd_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            srst_i,
  input  wire pcd_gate_s [7:0] gate_i,
  output logic           [7:0] on_o
);
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      on_o <= 8'hff;
    else
      for (int i = 0; i < 8; i++)
        on_o[i] <= on_o[i] ^ gate_i[i].wr_en;
  end
endmodule

`default_nettype wire

// ---- test_peripheral_clock_disable.sv ----
/*
  Testbench for the peripheral clock disable block.
  Assumes the default parameters: 8 peripherals, 2 clocks of delay.
*/
`timescale 1ns/100ps
`default_nettype none

module test_peripheral_clock_disable
  import pcd_pkg::*;
;
  logic            mclk_i = 0;
  logic            srst_i = 1;
  logic            ctl_wr_i = 0;
  logic      [7:0] ctl_wdata_i = 0;
  logic      [7:0] periph_wr_i = 0;
  logic      [7:0] on, rdata, ren, cen, wen;
  logic      [7:0] en_exp = 8'hff;
  logic      [7:0] on_exp = 8'hff;
  logic     [31:0] r;
  logic            pending;
  pcd_gate_s [7:0] gate;
  int              errors = 0;
  int              check_count = 0;
  int              cycles = 0;
  int              seed = 47643;

  pcd_top i_dut (.mclk_i, .srst_i, .ctl_wr_i, .ctl_wdata_i,
    .periph_on_i(on), .periph_wr_i, .ctl_rdata_o(rdata),
    .pending_o(pending), .gate_o(gate));
  pcd_periph_model i_periph (.mclk_i, .srst_i, .gate_i(gate), .on_o(on));

  initial
    forever #2 mclk_i = ~mclk_i;

  always_comb
    for (int i = 0; i < 8; i++)
    begin
      ren[i] = gate[i].rd_ok;
      cen[i] = gate[i].clk_en;
      wen[i] = gate[i].wr_en;
    end

  function automatic logic [7:0] en_of(logic [7:0] dis);
    return ~dis & PCD_PRESENT;
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic set_dis(logic [7:0] d);
    ctl_wr_i = 1;
    ctl_wdata_i = d;
    @(negedge mclk_i);
    ctl_wr_i = 0;
    chk(rdata, d & PCD_PRESENT);
    chk({7'h00, pending}, 8'h01);
    @(negedge mclk_i);
    chk(ren, en_exp);
    @(negedge mclk_i);
    en_exp = en_of(d);
    chk(ren, en_exp);
    chk({7'h00, pending}, 8'h00);
    chk(cen, en_exp & on_exp);
  endtask

  // Peripheral write, then the clock enable once its run bit has moved
  task automatic poke(logic [7:0] w);
    periph_wr_i = w;
    @(negedge mclk_i);
    periph_wr_i = 0;
    chk(wen, w & en_exp);
    on_exp = on_exp ^ (w & en_exp);
    repeat (2) @(negedge mclk_i);
    chk(cen, en_exp & on_exp);
  endtask

  // Two writes, adjacent or one idle cycle apart; the newest wins
  task automatic set_two(logic [7:0] d1, logic [7:0] d2, logic gap);
    ctl_wr_i = 1;
    ctl_wdata_i = d1;
    @(negedge mclk_i);
    if (gap)
    begin
      ctl_wr_i = 0;
      @(negedge mclk_i);
      ctl_wr_i = 1;
    end
    ctl_wdata_i = d2;
    @(negedge mclk_i);
    ctl_wr_i = 0;
    if (gap)
      en_exp = en_of(d1);
    chk(ren, en_exp);
    @(negedge mclk_i);
    chk(ren, en_exp);
    @(negedge mclk_i);
    en_exp = en_of(d2);
    chk(ren, en_exp);
    chk(rdata, d2 & PCD_PRESENT);
    chk({7'h00, pending}, 8'h00);
    chk(cen, en_exp & on_exp);
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(negedge mclk_i);
    srst_i = 0;
    chk(rdata, 8'h00);
    chk(ren, PCD_PRESENT);
    @(negedge mclk_i);
    set_dis(8'hff);
    poke(8'hff);
    set_dis(8'h00);
    poke(8'h0f);
    set_two(8'h0f, 8'hf0, 1'b0);
    set_two(8'h3c, 8'hc3, 1'b1);
    for (int n = 0; n < 200; n++)
    begin
      r = $random(seed);
      set_dis(r[7:0]);
      poke(r[15:8]);
      set_two(r[23:16], r[31:24], n[0]);
    end
    // Reset in mid-run with a write still pending
    ctl_wr_i = 1;
    ctl_wdata_i = 8'h5a;
    @(negedge mclk_i);
    ctl_wr_i = 0;
    srst_i = 1;
    repeat (2) @(negedge mclk_i);
    srst_i = 0;
    on_exp = 8'hff;
    en_exp = 8'hff;
    chk(rdata, 8'h00);
    chk({7'h00, pending}, 8'h00);
    chk(cen, 8'h00);
    repeat (2) @(negedge mclk_i);
    chk(ren, PCD_PRESENT);
    chk(cen, en_exp & on_exp);
    end_of_test();
  end
endmodule

`default_nettype wire
